// >>> common/compare_timer_cfg.svh
`ifndef COMPARE_TIMER_CFG_SVH
`define COMPARE_TIMER_CFG_SVH

// Register byte addresses
`define OFS_PORT4_DIR    16'hFF24
`define OFS_PORT4_LATCH  16'hFF28
`define OFS_MODE_CTRL    16'hFF70
`define OFS_CYCLE_CMP    16'hFF74
`define OFS_DUTY_CMP     16'hFF78
`define OFS_COUNT_STAT   16'hFF7C

// Reset values
`define RST_PORT4_DIR    8'hFF
`define RST_PORT4_LATCH  8'h00
`define RST_MODE_CTRL    8'h00
`define RST_CYCLE_CMP    8'h00
`define RST_DUTY_CMP     8'h00

// Mode control run bit and port 4 timer pin bit
`define MODE_RUN_BIT     7
`define TIMER_PIN_BIT    2

// Clock select codes
`define CKS_DIV1         3'h0
`define CKS_DIV4         3'h1
`define CKS_DIV16        3'h2
`define CKS_DIV64        3'h3
`define CKS_DIV4096      3'h4
`define CKS_LSO_DIV128   3'h5

// Operating mode codes
`define OPM_INTERVAL     2'h0
`define OPM_PWM          2'h2

// Count clocks a pending duty value must age before transfer
`define DUTY_AGE_MIN     2'h3

`endif

// >>> common/compare_timer_pkg.sv
package compare_timer_pkg;

  // Mode control register layout, msb first
  typedef struct packed {
    logic       run;
    logic [2:0] cks;
    logic [1:0] opm;
    logic       lev;
    logic       en;
  } mode_ctrl_t;

  // Which compare register the counter is matched against
  typedef enum logic {
    SEL_CYCLE,
    SEL_DUTY
  } cmp_sel_t;

endpackage

// >>> rtl/compare_timer.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "compare_timer_cfg.svh"

module compare_timer
  import compare_timer_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Slow oscillator, one pulse per period
  input  wire logic              low_speed_osc_rate,
  // Timer events and output
  output logic                   match_interrupt_request,
  output logic                   timer_output_pin,
  // Port 4 pins
  input  wire logic [7:0]        port4_in,
  output logic [7:0]             port4_out,
  output logic [7:0]             port4_oe
);

  if (ADDR_W < 16) begin : g_addr_chk
    $error("ADDR_W must reach the register addresses");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and shared signals

  mode_ctrl_t mode_r;
  logic [7:0] dir_r;
  logic [7:0] latch_r;
  logic [7:0] cycle_r;
  logic [7:0] duty_r;
  logic [7:0] duty_buf_r;
  logic duty_pend_r;
  logic [1:0] duty_age_r;
  logic [7:0] cnt_r;
  cmp_sel_t sel_r;
  logic mask_r, act_r, irq_r, tout_r;
  logic [11:0] pre_r;
  logic [6:0] lso_cnt_r;
  logic [31:0] prdata_r;
  logic lso_tick, tick, pwm, count_en, cyc_hit, duty_hit;
  logic wr_acc, wr_mode, wr_cycle, wr_duty;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [15:0] w;
    w = a[15:0];
    return ((a >> 16) == '0) &&
           (w == `OFS_PORT4_DIR || w == `OFS_PORT4_LATCH || w == `OFS_MODE_CTRL ||
            w == `OFS_CYCLE_CMP || w == `OFS_DUTY_CMP || w == `OFS_COUNT_STAT);
  endfunction

  function automatic logic hit_addr(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
    return ((a >> 16) == '0) && (a[15:0] == ofs);
  endfunction

  // Divider taps are all-ones points of a free prescaler, so a tick is one clk wide
  function automatic logic sel_tick(input logic [2:0] cks, input logic [11:0] pre,
                                    input logic slow);
    case (cks)
      `CKS_DIV1:       return 1'b1;
      `CKS_DIV4:       return &pre[1:0];
      `CKS_DIV16:      return &pre[3:0];
      `CKS_DIV64:      return &pre[5:0];
      `CKS_DIV4096:    return &pre[11:0];
      `CKS_LSO_DIV128: return slow;
      default:         return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, no wait states

  assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
  assign wr_mode = wr_acc && hit_addr(paddr, `OFS_MODE_CTRL);
  assign wr_cycle = wr_acc && hit_addr(paddr, `OFS_CYCLE_CMP);
  assign wr_duty = wr_acc && hit_addr(paddr, `OFS_DUTY_CMP);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = prdata_r;

  // Read data captured in the setup phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (hit_addr(paddr, `OFS_PORT4_DIR)) prdata_r[7:0] <= dir_r;
      if (hit_addr(paddr, `OFS_PORT4_LATCH)) prdata_r[7:0] <= latch_r;
      if (hit_addr(paddr, `OFS_MODE_CTRL)) prdata_r[7:0] <= mode_r;
      if (hit_addr(paddr, `OFS_CYCLE_CMP)) prdata_r[7:0] <= cycle_r;
      if (hit_addr(paddr, `OFS_DUTY_CMP)) prdata_r[7:0] <= duty_buf_r;
      if (hit_addr(paddr, `OFS_COUNT_STAT)) prdata_r[7:0] <= cnt_r;
    end
  end

  // While running only the run bit may change; the rest is locked
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_r <= `RST_MODE_CTRL;
    end else if (wr_mode) begin
      if (mode_r.run) begin
        mode_r.run <= pwdata[`MODE_RUN_BIT];
      end else begin
        mode_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_r <= `RST_PORT4_DIR;
      latch_r <= `RST_PORT4_LATCH;
    end else if (wr_acc) begin
      if (hit_addr(paddr, `OFS_PORT4_DIR)) dir_r <= pwdata[7:0];
      if (hit_addr(paddr, `OFS_PORT4_LATCH)) latch_r <= pwdata[7:0];
    end
  end

  // Cycle writes while running are dropped to avoid spurious matches
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cycle_r <= `RST_CYCLE_CMP;
    end else if (wr_cycle && !mode_r.run) begin
      cycle_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count clock

  assign lso_tick = low_speed_osc_rate && (&lso_cnt_r);
  assign tick = sel_tick(mode_r.cks, pre_r, lso_tick);
  assign pwm = (mode_r.opm == `OPM_PWM);
  // Prescaler runs free, so the first tick comes within one count clock
  assign count_en = mode_r.run && tick && !(mask_r && pwm);
  assign cyc_hit = count_en && (sel_r == SEL_CYCLE) && (cnt_r == cycle_r);
  assign duty_hit = count_en && (sel_r == SEL_DUTY) && (cnt_r == duty_r);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_r <= 12'h000;
      lso_cnt_r <= 7'h00;
    end else begin
      pre_r <= pre_r + 12'h001;
      if (low_speed_osc_rate) lso_cnt_r <= lso_cnt_r + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and compare selection

  always_ff @(posedge clk) begin
    if (!nrst || !mode_r.run) begin
      cnt_r <= 8'h00;
      sel_r <= SEL_CYCLE;
      mask_r <= 1'b1;
    end else if (tick) begin
      mask_r <= 1'b0;
      if (count_en) begin
        case (sel_r)
          SEL_CYCLE: begin
            if (cnt_r == cycle_r) begin
              cnt_r <= 8'h00;
              sel_r <= pwm ? SEL_DUTY : SEL_CYCLE;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          SEL_DUTY: begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == duty_r) sel_r <= SEL_CYCLE;
          end
          default: sel_r <= SEL_CYCLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty compare with deferred update

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_r <= `RST_DUTY_CMP;
      duty_buf_r <= `RST_DUTY_CMP;
      duty_pend_r <= 1'b0;
    end else if (wr_duty) begin
      duty_buf_r <= pwdata[7:0];
      if (!mode_r.run) begin
        duty_r <= pwdata[7:0];
        duty_pend_r <= 1'b0;
      end else begin
        duty_pend_r <= 1'b1;
      end
    end else if (!mode_r.run) begin
      duty_r <= duty_buf_r;
      duty_pend_r <= 1'b0;
    end else if (duty_hit && duty_pend_r && duty_age_r >= `DUTY_AGE_MIN) begin
      duty_r <= duty_buf_r;
      duty_pend_r <= 1'b0;
    end
  end

  // Too young at a match: value stays pending for a later match
  always_ff @(posedge clk) begin
    if (!nrst || wr_duty) begin
      duty_age_r <= 2'h0;
    end else if (duty_pend_r && tick && duty_age_r < `DUTY_AGE_MIN) begin
      duty_age_r <= duty_age_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request and timer output

  always_ff @(posedge clk) begin
    if (!nrst || !mode_r.run) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= cyc_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !mode_r.run) begin
      act_r <= 1'b0;
    end else if (cyc_hit) begin
      act_r <= pwm ? 1'b1 : !act_r;
    end else if (duty_hit) begin
      act_r <= 1'b0;
    end
  end

  // Registered pin level lags the active state by one clk
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tout_r <= 1'b0;
    end else begin
      tout_r <= mode_r.en ? (mode_r.lev ^ act_r) : 1'b0;
    end
  end

  assign match_interrupt_request = irq_r;
  assign timer_output_pin = tout_r;

  // Timer drives the shared pin only through a cleared latch and output direction
  always_comb begin
    port4_out = latch_r;
    port4_out[`TIMER_PIN_BIT] = latch_r[`TIMER_PIN_BIT] | tout_r;
    port4_oe = ~dir_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  stop_clears_a: assert property (!mode_r.run |=> cnt_r == 8'h00 && !irq_r)
    else $error("counter or request not cleared while stopped");
  stop_output_a: assert property (!mode_r.run ##1 !mode_r.run |=>
      tout_r == ($past(mode_r.en) & $past(mode_r.lev)))
    else $error("output not inactive while stopped");
  output_off_a: assert property (!mode_r.en |=> !tout_r)
    else $error("output drives while disabled");
  cycle_match_a: assert property (cyc_hit |=> irq_r && cnt_r == 8'h00)
    else $error("cycle match did not clear and request");
  irq_cause_a: assert property (irq_r |-> $past(cyc_hit))
    else $error("request without cycle match");
  square_toggle_a: assert property (cyc_hit && !pwm |=> act_r != $past(act_r))
    else $error("square wave did not toggle");
  interval_cycle_a: assert property (!pwm |-> sel_r == SEL_CYCLE)
    else $error("duty compare used in interval mode");
  pwm_active_a: assert property (cyc_hit && pwm |=> act_r && sel_r == SEL_DUTY)
    else $error("PWM cycle match mishandled");
  pwm_inactive_a: assert property (duty_hit |=>
      !act_r && sel_r == SEL_CYCLE && cnt_r == $past(cnt_r) + 8'h01 && !irq_r)
    else $error("PWM duty match mishandled");
  first_mask_a: assert property (mode_r.run && pwm && mask_r && tick |=>
      cnt_r == 8'h00 && !act_r)
    else $error("first PWM count clock not masked");
  duty_hold_a: assert property (mode_r.run && wr_duty |=> duty_r == $past(duty_r))
    else $error("duty changed on a running write");
  duty_defer_a: assert property (duty_hit && wr_duty |=> duty_pend_r)
    else $error("coinciding duty write not deferred");
  duty_young_a: assert property (duty_hit && duty_pend_r && duty_age_r < `DUTY_AGE_MIN
      |=> duty_r == $past(duty_r))
    else $error("young duty value transferred");
  mode_lock_a: assert property (mode_r.run && wr_mode |=>
      mode_r[6:0] == $past(mode_r[6:0]))
    else $error("mode bits changed while running");

  pwm_period_c: cover property (pwm && cyc_hit ##[1:20] duty_hit);
  duty_xfer_c: cover property (duty_hit && duty_pend_r && duty_age_r == `DUTY_AGE_MIN);
  square_wave_c: cover property (!pwm && mode_r.en && cyc_hit ##[1:20] cyc_hit);
  stop_run_c: cover property (act_r ##1 !mode_r.run);

endmodule // compare_timer

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "compare_timer_cfg.svh"

module tb
  import compare_timer_pkg::*;
;
  typedef struct {
    mode_ctrl_t m;
    logic [7:0] n;
    logic [7:0] d;
    int period;
    int high;
  } row_t;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic osc_pulse = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] port4_in = 8'hA5;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic pin;
  logic [7:0] p4_out;
  logic [7:0] p4_oe;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int sdiv = 0;

  // Mode byte, cycle, duty, period in clk, high samples per period (-1: toggle check)
  row_t rows [10] = '{
    '{8'h01, 8'h02, 8'h01, 3, -1},
    '{8'h11, 8'h02, 8'h00, 12, -1},
    '{8'h21, 8'h02, 8'h00, 48, -1},
    '{8'h31, 8'h02, 8'h00, 192, -1},
    '{8'h41, 8'h02, 8'h00, 12288, -1},
    '{8'h51, 8'h02, 8'h00, 1536, -1},
    '{8'h02, 8'h02, 8'h01, 3, 0},
    '{8'h09, 8'h04, 8'h01, 5, 2},
    '{8'h19, 8'h03, 8'h00, 16, 4},
    '{8'h0B, 8'h04, 8'h02, 5, 2}
  };
  logic [23:0] rst_tab [5] = '{
    {`OFS_PORT4_DIR, `RST_PORT4_DIR}, {`OFS_PORT4_LATCH, `RST_PORT4_LATCH},
    {`OFS_MODE_CTRL, `RST_MODE_CTRL}, {`OFS_CYCLE_CMP, `RST_CYCLE_CMP},
    {`OFS_DUTY_CMP, `RST_DUTY_CMP}
  };

  compare_timer dut (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .low_speed_osc_rate(osc_pulse),
    .match_interrupt_request(irq),
    .timer_output_pin(pin),
    .port4_in(port4_in),
    .port4_out(p4_out),
    .port4_oe(p4_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  // Slow oscillator stand-in, one pulse every 4 clk
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sdiv <= (sdiv == 3) ? 0 : sdiv + 1;
    osc_pulse <= (sdiv == 3);
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask

  // Samples at falling edges, where outputs have settled
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    @(negedge clk);
    while (irq !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) err_count++;
    t = cyc;
  endtask

  task automatic measure(input int period, input int high);
    int t0;
    int t1;
    int hi;
    logic p0;
    wait_irq(t0);
    hi = 0;
    p0 = 1'b0;
    for (int i = 0; i < period; i++) begin
      if (i > 0) @(negedge clk);
      if (pin === 1'b1) hi++;
      if (i == 2) p0 = pin;
    end
    wait_irq(t1);
    check(32'(t1 - t0), 32'(period));
    repeat (2) @(negedge clk);
    if (high < 0) check({31'h0, pin}, {31'h0, ~p0});
    else check(32'(hi), 32'(high));
  endtask

  // Stop, configure, rewrite duty, then start
  task automatic run_case(input row_t c);
    mode_ctrl_t m;
    m = c.m;
    wr(`OFS_MODE_CTRL, 8'h00);
    wr(`OFS_MODE_CTRL, m);
    wr(`OFS_CYCLE_CMP, c.n);
    wr(`OFS_DUTY_CMP, c.d);
    m.run = 1'b1;
    wr(`OFS_MODE_CTRL, m);
    measure(c.period, c.high);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    row_t hs;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_tab[i]) rd_chk(rst_tab[i][23:8], {24'h0, rst_tab[i][7:0]});
    apb(1'b0, 16'hFF00, 32'h0, r, e);
    check({e, r[30:0]}, 32'h80000000);
    @(negedge clk);
    check({24'h0, p4_oe}, 32'h0);
    foreach (rows[i]) run_case(rows[i]);
    // Writes while running: only run bit, duty and port 4 registers may change
    run_case(rows[0]);
    wr(`OFS_MODE_CTRL, 8'hFE);
    wr(`OFS_CYCLE_CMP, 8'h55);
    rd_chk(`OFS_MODE_CTRL, 32'h81);
    rd_chk(`OFS_CYCLE_CMP, 32'h02);
    measure(3, -1);
    // Stop from the active level of a high-default output
    hs = '{8'h03, 8'h02, 8'h00, 3, -1};
    run_case(hs);
    wr(`OFS_MODE_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    check({31'h0, pin}, 32'h1);
    n = 0;
    repeat (10) begin
      @(negedge clk);
      if (irq !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
    rd_chk(`OFS_COUNT_STAT, 32'h0);
    // Duty change on the fly, given time to age past three ticks
    run_case(rows[7]);
    wr(`OFS_DUTY_CMP, 8'h03);
    repeat (20) @(posedge clk);
    measure(5, 4);
    // Pin routed through port bit 2
    wr(`OFS_PORT4_DIR, 8'hFB);
    wr(`OFS_PORT4_LATCH, 8'h01);
    @(negedge clk);
    check({24'h0, p4_oe}, 32'h04);
    check({30'h0, p4_out[2], p4_out[0]}, {30'h0, pin, 1'b1});
    // Reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check({30'h0, irq, pin}, 32'h0);
    rd_chk(`OFS_MODE_CTRL, 32'h0);
    rd_chk(`OFS_PORT4_DIR, 32'hFF);
    summarize();
  end

  // Longest case is the /4096 row, near 25k clk
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule // tb

`default_nettype wire
